// ### hw/refsel_pkg.sv
/*
  Package for the reference selection control block: register offsets,
  field positions, reset values and the status-pin source codes.
  Assumes a byte-wide register port addressed by the offsets below.
*/
package refsel_pkg;

  localparam int          ADDR_W = 10;
  localparam int          DATA_W = 8;

  // Register offsets
  localparam logic [9:0]  REF_SEL_CTRL_ADDR   = 10'h01C;
  localparam logic [9:0]  REF_MISC_CTRL_ADDR  = 10'h01D;
  localparam logic [9:0]  STATUS_SEL_ADDR     = 10'h017;
  localparam logic [9:0]  PLL_STATUS_ADDR     = 10'h01F;

  // Reference selection control fields
  localparam int          SEL_DEGLITCH_OFF_BIT = 7;
  localparam int          SEL_SECONDARY_BIT    = 6;
  localparam int          SEL_USE_PIN_BIT      = 5;
  localparam int          SEL_AUTO_BIT         = 4;
  localparam int          SEL_STAY_SEC_BIT     = 3;
  localparam int          SEL_SEC_PWR_BIT      = 2;
  localparam int          SEL_PRI_PWR_BIT      = 1;
  localparam int          SEL_DIFF_BIT         = 0;

  // Misc control fields
  localparam int          MISC_NVM_STATUS_BIT  = 7;
  localparam int          MISC_XTAL_AMP_BIT    = 6;
  localparam int          MISC_DOUBLER_BIT     = 5;
  localparam int          MISC_RDBK_OFF_BIT    = 4;

  // Status-pin selection field position in its register
  localparam int          STSEL_LSB            = 2;

  // Reset values
  localparam logic [7:0]  REF_SEL_CTRL_RST     = 8'h00;
  localparam logic [7:0]  REF_MISC_CTRL_RST    = 8'h80;
  localparam logic [7:0]  STATUS_SEL_RST       = 8'h00;

  // Deglitch: cycles the reference path is held still across a change
  localparam int          DEGLITCH_CYCLES      = 4;

  // Status-pin source codes handled here
  localparam logic [5:0]  STSEL_GROUND         = 6'h00;
  localparam logic [5:0]  STSEL_SEL_REF        = 6'h0C;
  localparam logic [5:0]  STSEL_LOCK_HI        = 6'h0D;
  localparam logic [5:0]  STSEL_HOLD_HI        = 6'h0E;
  localparam logic [5:0]  STSEL_SUPPLY         = 6'h10;
  localparam logic [5:0]  STSEL_SEL_REF_N      = 6'h1C;
  localparam logic [5:0]  STSEL_LOCK_LO        = 6'h1D;
  localparam logic [5:0]  STSEL_HOLD_LO        = 6'h1E;
  localparam logic [5:0]  STSEL_RESERVED       = 6'h1F;

  typedef struct packed {
    logic write;
    logic read;
    logic [9:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic primary_good;
    logic secondary_good;
    logic lock_detect;
    logic holdover_active;
    logic nvm_status;
  } pll_stat_s;

endpackage : refsel_pkg

// ### hw/ref_switch_fsm.sv
/*
  Reference switchover state machine with deglitch hold.
  Assumes status inputs are synchronous to the system clock.
*/
`timescale 1ns/1ns
module ref_switch_fsm
  import refsel_pkg::*;
(
  // Clock, reset and enable
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  input  wire logic ce_in,
  // Control and reference status
  input  wire logic auto_in,
  input  wire logic stay_sec_in,
  input  wire logic manual_sec_in,
  input  wire logic deglitch_off_in,
  input  wire logic primary_good_in,
  input  wire logic secondary_good_in,
  // Result
  output logic      use_secondary_out,
  output logic      switching_out
);
  import refsel_pkg::*;

  typedef enum logic [1:0] {ST_PRI, ST_SEC} sel_e;

  sel_e                 state_q;
  logic [3:0]           hold_q;
  logic                 want_sec;
  logic                 cur_sec;

  always_comb
  begin
    cur_sec = (state_q == ST_SEC);
    want_sec = cur_sec;
    if (!auto_in)
      want_sec = manual_sec_in;
    else
      case (state_q)
        ST_PRI:  want_sec = !primary_good_in && secondary_good_in;
        ST_SEC:  want_sec = !(primary_good_in && !stay_sec_in); // RL6
        default: want_sec = 1'b0;
      endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state_q <= ST_PRI;
      hold_q  <= 4'h0;
    end
    else if (ce_in)
    begin
      if (hold_q != 4'h0)
        hold_q <= hold_q - 4'h1;
      else if (want_sec != cur_sec)
      begin
        state_q <= want_sec ? ST_SEC : ST_PRI;
        if (!deglitch_off_in)
          hold_q <= 4'(DEGLITCH_CYCLES); // RL16
      end
    end
  end

  assign use_secondary_out = cur_sec;
  assign switching_out     = (hold_q != 4'h0);

endmodule : ref_switch_fsm

// ### hw/refsel_ctrl.sv
/*
  Reference selection control: registers at 0x017, reference_selection_control, reference_input_misc_control and 0x01F,
  reference choice, input power and mode, status-pin source.
  Assumes a synchronous byte-wide register port from the serial control
  port and status inputs synchronous to sys_clk_in.
*/
// Functional notes
// RL1: Upper status codes give lock detect or holdover active low; all-ones reserved.
// RL2: Manual register select: bit 6 one picks secondary, zero picks primary.
// RL3: Bit 5 chooses register bit or select pin for manual choice.
// RL4: Software clears differential mode before enabling automatic switchover.
// RL5: Automatic switchover powers both inputs, ignoring individual enables.
// RL6: Automatic mode reverts to primary when good unless stay-on-secondary set.
// RL7: Bits 2 and 1 power secondary and primary inputs, off by default.
// RL8: Bit 0 selects differential mode; zero is single-ended.
// RL9: Software clears both power enables when setting differential mode.
// RL10: Override bit zero: status pin follows selection field.
// RL11: Override bit one (default): status pin shows memory status.
// RL12: Bit 6 of misc register enables crystal amplifier.
// RL13: Bit 5 of misc register enables reference doubler.
// RL14: Bit 4 of misc register disables status readback.
// RL15: While readback disabled, status register stops updating.
// RL16: Bit 7 bypasses switchover deglitch; default keeps deglitch active.
`timescale 1ns/1ns
module refsel_ctrl
(
  // Clock, reset, enable
  input  wire logic                 sys_clk_in,
  input  wire logic                 rstn_in,
  input  wire logic                 ce_in,
  // Register port
  input  wire refsel_pkg::reg_req_s reg_req_in,
  output logic [7:0]                reg_rdata_out,
  output logic                      reg_rvalid_out,
  // Pins and analog status
  input  wire logic                 ref_sel_pin_in,
  input  wire refsel_pkg::pll_stat_s pll_stat_in,
  // Controls to analog and status pin
  output logic                      secondary_sel_out,
  output logic                      primary_pwr_out,
  output logic                      secondary_pwr_out,
  output logic                      diff_mode_out,
  output logic                      crystal_amp_en_out,
  output logic                      doubler_en_out,
  output logic                      ref_switching_out,
  output logic                      status_pin_out
);
  import refsel_pkg::*;

  logic [7:0]           sel_ctrl_q;
  logic [7:0]           misc_ctrl_q;
  logic [7:0]           stsel_q;
  logic [7:0]           pll_status_q;
  logic                 use_sec;
  logic                 switching;
  logic                 manual_sec;
  logic                 pin_d;
  logic [5:0]           code;

  function automatic logic hit(input reg_req_s r, input logic [9:0] a);
    hit = (r.addr == a);
  endfunction : hit

  // Register writes
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      sel_ctrl_q  <= REF_SEL_CTRL_RST;
      misc_ctrl_q <= REF_MISC_CTRL_RST;
      stsel_q     <= STATUS_SEL_RST;
    end
    else if (ce_in && reg_req_in.write)
    begin
      if (hit(reg_req_in, REF_SEL_CTRL_ADDR))
        sel_ctrl_q <= reg_req_in.wdata;
      if (hit(reg_req_in, REF_MISC_CTRL_ADDR))
        misc_ctrl_q <= reg_req_in.wdata;
      if (hit(reg_req_in, STATUS_SEL_ADDR))
        stsel_q <= reg_req_in.wdata;
    end
  end

  // Status snapshot
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pll_status_q <= 8'h00;
    else if (ce_in && !misc_ctrl_q[MISC_RDBK_OFF_BIT]) // RL15
      pll_status_q <= {3'h0, pll_stat_in.primary_good, pll_stat_in.secondary_good,
                       pll_stat_in.lock_detect, pll_stat_in.holdover_active, use_sec};
  end

  // Register reads
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end
    else if (ce_in)
    begin
      reg_rvalid_out <= reg_req_in.read;
      reg_rdata_out  <= 8'h00;
      if (reg_req_in.read)
      begin
        if (hit(reg_req_in, REF_SEL_CTRL_ADDR))
          reg_rdata_out <= sel_ctrl_q;
        else if (hit(reg_req_in, REF_MISC_CTRL_ADDR))
          reg_rdata_out <= misc_ctrl_q;
        else if (hit(reg_req_in, STATUS_SEL_ADDR))
          reg_rdata_out <= stsel_q;
        else if (hit(reg_req_in, PLL_STATUS_ADDR) && !misc_ctrl_q[MISC_RDBK_OFF_BIT])
          reg_rdata_out <= pll_status_q; // RL14
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pin_d <= 1'b0;
    else if (ce_in)
      pin_d <= ref_sel_pin_in;
  end

  always_comb
  begin
    if (sel_ctrl_q[SEL_USE_PIN_BIT])
      manual_sec = pin_d; // RL3
    else
      manual_sec = sel_ctrl_q[SEL_SECONDARY_BIT]; // RL2
  end

  ref_switch_fsm u_fsm
  (
    .sys_clk_in        (sys_clk_in),
    .rstn_in           (rstn_in),
    .ce_in             (ce_in),
    .auto_in           (sel_ctrl_q[SEL_AUTO_BIT]),
    .stay_sec_in       (sel_ctrl_q[SEL_STAY_SEC_BIT]),
    .manual_sec_in     (manual_sec),
    .deglitch_off_in   (sel_ctrl_q[SEL_DEGLITCH_OFF_BIT]),
    .primary_good_in   (pll_stat_in.primary_good),
    .secondary_good_in (pll_stat_in.secondary_good),
    .use_secondary_out (use_sec),
    .switching_out     (switching)
  );

  // Analog controls
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      secondary_sel_out  <= 1'b0;
      primary_pwr_out    <= 1'b0;
      secondary_pwr_out  <= 1'b0;
      diff_mode_out      <= 1'b0;
      crystal_amp_en_out <= 1'b0;
      doubler_en_out     <= 1'b0;
      ref_switching_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      secondary_sel_out  <= use_sec;
      primary_pwr_out    <= sel_ctrl_q[SEL_AUTO_BIT] | sel_ctrl_q[SEL_PRI_PWR_BIT]; // RL5 RL7
      secondary_pwr_out  <= sel_ctrl_q[SEL_AUTO_BIT] | sel_ctrl_q[SEL_SEC_PWR_BIT]; // RL5 RL7
      diff_mode_out      <= sel_ctrl_q[SEL_DIFF_BIT]; // RL8
      crystal_amp_en_out <= misc_ctrl_q[MISC_XTAL_AMP_BIT]; // RL12
      doubler_en_out     <= misc_ctrl_q[MISC_DOUBLER_BIT]; // RL13
      ref_switching_out  <= switching;
    end
  end

  // Status pin source
  assign code = stsel_q[7:STSEL_LSB];

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      status_pin_out <= 1'b0;
    else if (ce_in)
    begin
      if (misc_ctrl_q[MISC_NVM_STATUS_BIT])
        status_pin_out <= pll_stat_in.nvm_status; // RL11
      else
        case (code) // RL10
          STSEL_SEL_REF:   status_pin_out <= use_sec;
          STSEL_LOCK_HI:   status_pin_out <= pll_stat_in.lock_detect;
          STSEL_HOLD_HI:   status_pin_out <= pll_stat_in.holdover_active;
          STSEL_SUPPLY:    status_pin_out <= 1'b1;
          STSEL_SEL_REF_N: status_pin_out <= !use_sec;
          STSEL_LOCK_LO:   status_pin_out <= !pll_stat_in.lock_detect; // RL1
          STSEL_HOLD_LO:   status_pin_out <= !pll_stat_in.holdover_active; // RL1
          STSEL_RESERVED:  status_pin_out <= 1'b0; // RL1
          default:         status_pin_out <= 1'b0;
        endcase
    end
  end

endmodule : refsel_ctrl

// ### tb/ref_source_model.sv
/* Far-side model: reference status flags and memory status level.
   Assumes the bench sets the wanted flags just after a clock edge. */
`timescale 1ns/1ns
module ref_source_model
(
  input  wire logic                  sys_clk_in,
  input  wire logic [4:0]            want_in,
  output refsel_pkg::pll_stat_s      stat_out
);
  import refsel_pkg::*;
  // Flags change on the edge, so the block sees them one edge later
  always_ff @(posedge sys_clk_in) stat_out <= want_in;
endmodule : ref_source_model

// ### tb/refsel_ctrl_asserts.sv
/* Port checker for the reference selection block.
   Assumes binding to refsel_ctrl and a single clock domain. */
`timescale 1ns/1ns
module refsel_ctrl_asserts
(
  input wire logic                 sys_clk_in,
  input wire logic                 rstn_in,
  input wire logic                 ce_in,
  input wire refsel_pkg::reg_req_s reg_req_in,
  input wire logic                 primary_pwr_out,
  input wire logic                 secondary_pwr_out,
  input wire logic                 diff_mode_out,
  input wire logic                 crystal_amp_en_out,
  input wire logic                 doubler_en_out,
  input wire logic                 ref_switching_out
);
  import refsel_pkg::*;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);
  logic w_sel;
  logic w_misc;
  assign w_sel  = reg_req_in.write && ce_in && reg_req_in.addr == REF_SEL_CTRL_ADDR;
  assign w_misc = reg_req_in.write && ce_in && reg_req_in.addr == REF_MISC_CTRL_ADDR;
  a_auto_powers_both: assert property (w_sel && reg_req_in.wdata[4]
    |-> ##2 primary_pwr_out && secondary_pwr_out) else $error("auto mode left an input off");
  a_manual_power_bits: assert property (w_sel && !reg_req_in.wdata[4]
    |-> ##2 {secondary_pwr_out, primary_pwr_out} == $past(reg_req_in.wdata[2:1], 2))
    else $error("power enables differ from written bits");
  a_diff_mode_bit: assert property (w_sel
    |-> ##2 diff_mode_out == $past(reg_req_in.wdata[0], 2)) else $error("mode bit wrong");
  a_diff_mode_held: assert property ($changed(diff_mode_out) |-> $past(w_sel, 2))
    else $error("mode changed without a write");
  a_crystal_amp_bit: assert property (w_misc
    |-> ##2 crystal_amp_en_out == $past(reg_req_in.wdata[6], 2)) else $error("amp bit wrong");
  a_crystal_amp_held: assert property ($changed(crystal_amp_en_out) |-> $past(w_misc, 2))
    else $error("amp changed without a write");
  a_doubler_bit: assert property (w_misc
    |-> ##2 doubler_en_out == $past(reg_req_in.wdata[5], 2)) else $error("doubler bit wrong");
  a_deglitch_hold: assert property ($rose(ref_switching_out)
    |-> ref_switching_out [*4] ##1 !ref_switching_out) else $error("hold not four cycles");
endmodule : refsel_ctrl_asserts
bind refsel_ctrl refsel_ctrl_asserts refsel_ctrl_asserts_i (.sys_clk_in, .rstn_in, .ce_in,
  .reg_req_in, .primary_pwr_out, .secondary_pwr_out, .diff_mode_out, .crystal_amp_en_out,
  .doubler_en_out, .ref_switching_out);

// ### tb/refsel_ctrl_tb.sv
/* Self-checking bench for the reference selection block.
   Assumes the source model and bound checker are compiled alongside. */
`timescale 1ns/1ns
module refsel_ctrl_tb;
  import refsel_pkg::*;
  logic       sys_clk_in = 1'b0;
  logic       rstn_in = 1'b0;
  logic       ce_in = 1'b1;
  logic       ref_sel_pin_in = 1'b0;
  logic [4:0] want = 5'h01;
  logic [7:0] n;
  reg_req_s   reg_req_in = '0;
  pll_stat_s  pll_stat_in;
  logic [7:0] reg_rdata_out;
  logic       reg_rvalid_out, secondary_sel_out, primary_pwr_out, secondary_pwr_out;
  logic       diff_mode_out, crystal_amp_en_out, doubler_en_out, ref_switching_out;
  logic       status_pin_out;
  int         fails = 0;
  int         tests_run = 0;
  always #20 sys_clk_in = ~sys_clk_in;
  refsel_ctrl refsel_ctrl_i (.sys_clk_in, .rstn_in, .ce_in, .reg_req_in, .reg_rdata_out,
    .reg_rvalid_out, .ref_sel_pin_in, .pll_stat_in, .secondary_sel_out, .primary_pwr_out,
    .secondary_pwr_out, .diff_mode_out, .crystal_amp_en_out, .doubler_en_out,
    .ref_switching_out, .status_pin_out);
  ref_source_model ref_source_model_i (.sys_clk_in, .want_in(want), .stat_out(pll_stat_in));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk_in);
    #1;
  endtask : cyc
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input int k);
    reg_req_in = '{1'b1, 1'b0, a, d};
    cyc(1);
    reg_req_in = '0;
    cyc(k);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    reg_req_in = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    reg_req_in = '0;
    chk(8'(reg_rvalid_out), 8'h01);
    chk(reg_rdata_out, exp);
    cyc(1);
  endtask : rd
  task automatic count_hold();
    n = 8'h00;
    repeat (12)
    begin
      cyc(1);
      n = n + 8'(ref_switching_out);
    end
  endtask : count_hold
  task automatic t_reset();
    rd(REF_SEL_CTRL_ADDR, 8'h00);
    rd(REF_MISC_CTRL_ADDR, 8'h80);
    rd(STATUS_SEL_ADDR, 8'h00);
    chk(8'(status_pin_out), 8'h01);
  endtask : t_reset
  task automatic t_manual();
    wr(REF_SEL_CTRL_ADDR, 8'h46, 10);
    chk(8'({secondary_sel_out, secondary_pwr_out, primary_pwr_out}), 8'h07);
    wr(REF_SEL_CTRL_ADDR, 8'h20, 10);
    chk(8'({secondary_sel_out, secondary_pwr_out, primary_pwr_out}), 8'h00);
    ref_sel_pin_in = 1'b1;
    count_hold();
    chk(n, 8'h04);
    chk(8'(secondary_sel_out), 8'h01);
    wr(REF_SEL_CTRL_ADDR, 8'hA0, 1);
    ref_sel_pin_in = 1'b0;
    count_hold();
    chk(n, 8'h00);
    chk(8'(secondary_sel_out), 8'h00);
  endtask : t_manual
  task automatic t_auto();
    want = 5'h18;
    wr(REF_SEL_CTRL_ADDR, 8'h10, 12);
    chk(8'({secondary_pwr_out, primary_pwr_out}), 8'h03);
    want = 5'h08;
    cyc(12);
    chk(8'(secondary_sel_out), 8'h01);
    want = 5'h18;
    cyc(12);
    chk(8'(secondary_sel_out), 8'h00);
    wr(REF_SEL_CTRL_ADDR, 8'h18, 1);
    want = 5'h08;
    cyc(12);
    want = 5'h1C;
    cyc(12);
    chk(8'(secondary_sel_out), 8'h01);
    rd(PLL_STATUS_ADDR, 8'h1D);
    wr(REF_MISC_CTRL_ADDR, 8'h10, 3);
    rd(PLL_STATUS_ADDR, 8'h00);
    rd(10'h3FF, 8'h00);
    want = 5'h12;
    cyc(3);
    reg_req_in = '{1'b1, 1'b0, REF_MISC_CTRL_ADDR, 8'h00};
    cyc(1);
    reg_req_in = '{1'b0, 1'b1, PLL_STATUS_ADDR, 8'h00};
    cyc(1);
    reg_req_in = '0;
    chk(reg_rdata_out, 8'h1D);
    cyc(1);
    rd(PLL_STATUS_ADDR, 8'h13);
  endtask : t_auto
  task automatic t_misc();
    want = 5'h01;
    wr(REF_MISC_CTRL_ADDR, 8'hE0, 3);
    chk(8'({crystal_amp_en_out, doubler_en_out, status_pin_out}), 8'h07);
    wr(REF_MISC_CTRL_ADDR, 8'h00, 1);
    wr(STATUS_SEL_ADDR, 8'h74, 3);
    chk(8'({crystal_amp_en_out, doubler_en_out, status_pin_out}), 8'h01);
    want = 5'h04;
    cyc(3);
    chk(8'(status_pin_out), 8'h00);
    wr(STATUS_SEL_ADDR, 8'h34, 3);
    chk(8'(status_pin_out), 8'h01);
    want = 5'h02;
    wr(STATUS_SEL_ADDR, 8'h78, 3);
    chk(8'(status_pin_out), 8'h00);
    wr(REF_SEL_CTRL_ADDR, 8'h01, 3);
    chk(8'({diff_mode_out, secondary_pwr_out, primary_pwr_out}), 8'h04);
    wr(STATUS_SEL_ADDR, 8'h40, 3);
    chk(8'(status_pin_out), 8'h01);
    wr(STATUS_SEL_ADDR, 8'h70, 3);
    chk(8'(status_pin_out), 8'h01);
    wr(STATUS_SEL_ADDR, 8'h30, 3);
    chk(8'(status_pin_out), 8'h00);
    wr(STATUS_SEL_ADDR, 8'h38, 3);
    chk(8'(status_pin_out), 8'h01);
    wr(STATUS_SEL_ADDR, 8'h7C, 3);
    chk(8'(status_pin_out), 8'h00);
    ce_in = 1'b0;
    wr(REF_MISC_CTRL_ADDR, 8'h60, 3);
    ce_in = 1'b1;
    rd(REF_MISC_CTRL_ADDR, 8'h00);
    chk(8'({crystal_amp_en_out, doubler_en_out}), 8'h00);
  endtask : t_misc
  task automatic t_reset_again();
    rstn_in = 1'b0;
    cyc(1);
    rstn_in = 1'b1;
    cyc(1);
    rd(REF_MISC_CTRL_ADDR, 8'h80);
    rd(REF_SEL_CTRL_ADDR, 8'h00);
    chk(8'({diff_mode_out, secondary_pwr_out, primary_pwr_out}), 8'h00);
  endtask : t_reset_again
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
  initial
  begin
    cyc(2);
    rstn_in = 1'b1;
    cyc(1);
    t_reset();
    t_manual();
    t_auto();
    t_misc();
    t_reset_again();
    conclude();
  end
endmodule : refsel_ctrl_tb
